/* File: rtl/spips_pkg.sv */
// package: register map, field positions and reset values for the spi prescaler and status block
package spips_pkg;
    localparam logic [7:0] SERIAL_CLOCK_DIVIDER_ADDR = 8'hD2;
    localparam logic [7:0] SERIAL_PORT_STATUS_ADDR   = 8'hD3;
    localparam logic [7:0] DIVIDER_RESET             = 8'h04;
    localparam logic [7:0] STATUS_RESET              = 8'h02;
    localparam logic [7:0] DIVIDER_WRITE_MASK        = 8'hFC;
    // status bit positions
    localparam int BUSY_BIT  = 4;
    localparam int TEND_BIT  = 3;
    localparam int ROVR_BIT  = 2;
    localparam int TEMPT_BIT = 1;
    localparam int RFULL_BIT = 0;
    // divider bit positions
    localparam int DIVIDE_BY_ONE_TWENTY_EIGHT_BIT = 7;
    localparam int DIVIDE_BY_FOUR_BIT   = 2;
    // enable-bit positions in the irq enable input
    localparam int TEND_IE_BIT  = 3;
    localparam int ROVR_IE_BIT  = 2;
    localparam int TEMPT_IE_BIT = 1;
    localparam int RFULL_IE_BIT = 0;

    // events from the shift engine
    typedef struct packed {
        logic busy;          // transfer in progress (level)
        logic tx_end;        // transmission end (pulse)
        logic rx_overrun;    // receive overrun (pulse)
        logic tx_loaded;     // byte moved from transmit buffer to shifter (pulse)
        logic rx_filled;     // received byte written to receive buffer (pulse)
    } spips_event_t;

    // special-function-register bus access
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } spips_sfr_t;
endpackage : spips_pkg

/* File: rtl/spips_core.sv */
// spi prescaler: divider register with one select bit per ratio, serial clock tick and status flags
`timescale 1ns/1ps
module spips_core #(
    parameter int DIV_W = 7                          // width of the prescale counter
) (
    input  wire logic                  core_clk,     // oscillator clock, 125 MHz
    input  wire logic                  rstn,         // synchronous reset, active low
    input  wire spips_pkg::spips_sfr_t sfr,          // register bus request
    input  wire logic                  tdb_wr,       // software writes transmit data buffer
    input  wire logic                  rdb_rd,       // software reads receive data buffer
    input  wire spips_pkg::spips_event_t evt,        // shift engine events
    input  wire logic [3:0]            irq_enable,   // enables: tend, ovr, tempt, rfull
    output logic [7:0]                 rdata,        // register read data
    output logic                       sclk_tick,    // one pulse per serial half period
    output logic                       irq           // combined interrupt request
);
    logic [7:0]       div_q;
    logic [4:0]       stat_q;
    logic [7:0]       rdata_q;
    logic             tick_q;
    logic             irq_q;
    logic [DIV_W-1:0] cnt_q;
    logic [DIV_W-1:0] limit;
    logic             stat_rd;
    logic             div_wr;
    logic [7:0]       gap_q;
    logic             div_moved_q;
    logic [7:0]       half_div;

    assign stat_rd = sfr.rd && (sfr.addr == spips_pkg::SERIAL_PORT_STATUS_ADDR);
    assign div_wr  = sfr.wr && (sfr.addr == spips_pkg::SERIAL_CLOCK_DIVIDER_ADDR);

    // divider register, only bits 7..2 are writable
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            div_q <= spips_pkg::DIVIDER_RESET;
        end else if (div_wr) begin
            div_q <= sfr.wdata & spips_pkg::DIVIDER_WRITE_MASK;
        end
    end

    // bits 1..0 are not divider bits and never hold a one
    a_div_unused: assert property (@(posedge core_clk) disable iff (!rstn)
        div_q[1:0] == 2'b00) else $error("unused divider bits set");
    a_div_write: assert property (@(posedge core_clk) disable iff (!rstn)
        div_wr |=> div_q == ($past(sfr.wdata) & spips_pkg::DIVIDER_WRITE_MASK))
        else $error("divider write lost");

    // terminal count: half the divisor minus one, largest selected wins
    always_comb begin
        limit = '0;
        for (int i = spips_pkg::DIVIDE_BY_FOUR_BIT; i <= spips_pkg::DIVIDE_BY_ONE_TWENTY_EIGHT_BIT; i++) begin
            if (div_q[i]) begin
                limit = DIV_W'((1 << (i - 1)) - 1);
            end
        end
    end

    // prescale counter; with no divider bit set the serial clock stops
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            cnt_q  <= '0;
            tick_q <= 1'b0;
        end else if (div_q == 8'h00) begin
            cnt_q  <= '0;
            tick_q <= 1'b0;
        end else if (cnt_q >= limit) begin
            cnt_q  <= '0;
            tick_q <= 1'b1;
        end else begin
            cnt_q  <= cnt_q + DIV_W'(1);
            tick_q <= 1'b0;
        end
    end

    // rate check helper: cycles since the last tick, and whether the divider
    // was written meanwhile, since a retuned prescaler owes one odd gap
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            gap_q       <= 8'h00;
            div_moved_q <= 1'b1;
        end else if (tick_q) begin
            gap_q       <= 8'h01;
            div_moved_q <= div_wr;
        end else begin
            gap_q       <= gap_q + 8'h01;
            div_moved_q <= div_moved_q | div_wr;
        end
    end

    // expected half period of one selected divider bit; zero when the setting
    // is not one-hot, as the rate is then only our own choice
    always_comb begin
        half_div = 8'h00;
        for (int i = spips_pkg::DIVIDE_BY_FOUR_BIT; i <= spips_pkg::DIVIDE_BY_ONE_TWENTY_EIGHT_BIT; i++) begin
            if (div_q == 8'(1 << i)) begin
                half_div = 8'(1 << (i - 1));
            end
        end
    end

    a_tick_period: assert property (@(posedge core_clk) disable iff (!rstn)
        tick_q && !div_moved_q && half_div != 8'h00 |-> gap_q == half_div)
        else $error("serial tick period wrong");
    a_tick_pulse: assert property (@(posedge core_clk) disable iff (!rstn)
        tick_q |=> !tick_q) else $error("serial tick longer than one cycle");

    // status flags: a hardware set always beats a software clear
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            stat_q <= spips_pkg::STATUS_RESET[4:0];
        end else begin
            stat_q[spips_pkg::BUSY_BIT] <= evt.busy;
            if (evt.tx_end) begin
                stat_q[spips_pkg::TEND_BIT] <= 1'b1;
            end else if (stat_rd) begin
                stat_q[spips_pkg::TEND_BIT] <= 1'b0;
            end
            if (evt.rx_overrun) begin
                stat_q[spips_pkg::ROVR_BIT] <= 1'b1;
            end else if (stat_rd) begin
                stat_q[spips_pkg::ROVR_BIT] <= 1'b0;
            end
            if (evt.tx_loaded) begin
                stat_q[spips_pkg::TEMPT_BIT] <= 1'b1;
            end else if (tdb_wr) begin
                stat_q[spips_pkg::TEMPT_BIT] <= 1'b0;
            end
            if (evt.rx_filled) begin
                stat_q[spips_pkg::RFULL_BIT] <= 1'b1;
            end else if (rdb_rd) begin
                stat_q[spips_pkg::RFULL_BIT] <= 1'b0;
            end
        end
    end

    // a flag with neither its set nor its clear pending keeps its value
    a_tend_hold: assert property (@(posedge core_clk) disable iff (!rstn)
        !evt.tx_end && !stat_rd |=> $stable(stat_q[spips_pkg::TEND_BIT]))
        else $error("tend flag moved unprompted");
    a_rfull_hold: assert property (@(posedge core_clk) disable iff (!rstn)
        !evt.rx_filled && !rdb_rd |=> $stable(stat_q[spips_pkg::RFULL_BIT]))
        else $error("rfull flag moved unprompted");

    // read data registered; unmapped addresses and reserved bits read zero
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            rdata_q <= 8'h00;
        end else if (sfr.rd && sfr.addr == spips_pkg::SERIAL_CLOCK_DIVIDER_ADDR) begin
            rdata_q <= div_q;
        end else if (stat_rd) begin
            rdata_q <= {3'h0, stat_q};
        end else begin
            rdata_q <= 8'h00;
        end
    end

    a_stat_read: assert property (@(posedge core_clk) disable iff (!rstn)
        stat_rd |=> rdata_q == {3'h0, $past(stat_q)}) else $error("status read data wrong");

    // interrupt request from enabled source flags
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(stat_q[3:0] & irq_enable);
        end
    end

    a_irq_raise: assert property (@(posedge core_clk) disable iff (!rstn)
        (stat_q[3:0] & irq_enable) != 4'h0 |=> irq_q) else $error("irq not raised");

    assign rdata     = rdata_q;
    assign sclk_tick = tick_q;
    assign irq       = irq_q;

    // checks
    a_div_reset: assert property (@(posedge core_clk) !rstn |=> div_q == 8'h04)
        else $error("divider reset value wrong");
    a_stat_reset: assert property (@(posedge core_clk) !rstn |=> stat_q == 5'h02)
        else $error("status reset value wrong");
    a_busy_follow: assert property (@(posedge core_clk) disable iff (!rstn)
        1'b1 |=> stat_q[4] == $past(evt.busy)) else $error("busy not tracking");
    a_tend_set: assert property (@(posedge core_clk) disable iff (!rstn)
        evt.tx_end |=> stat_q[3]) else $error("tend flag not set");
    a_stat_rdclr: assert property (@(posedge core_clk) disable iff (!rstn)
        stat_rd && !evt.tx_end && !evt.rx_overrun |=> !stat_q[3] && !stat_q[2])
        else $error("status read did not clear");
    a_ovr_set: assert property (@(posedge core_clk) disable iff (!rstn)
        evt.rx_overrun |=> stat_q[2]) else $error("overrun flag not set");
    a_tempt_clr: assert property (@(posedge core_clk) disable iff (!rstn)
        tdb_wr && !evt.tx_loaded |=> !stat_q[1]) else $error("tempty not cleared");
    a_tempt_set: assert property (@(posedge core_clk) disable iff (!rstn)
        evt.tx_loaded |=> stat_q[1]) else $error("tempty not set");
    a_rfull_clr: assert property (@(posedge core_clk) disable iff (!rstn)
        rdb_rd && !evt.rx_filled |=> !stat_q[0]) else $error("rfull not cleared");
    a_rfull_set: assert property (@(posedge core_clk) disable iff (!rstn)
        evt.rx_filled |=> stat_q[0]) else $error("rfull not set");
    a_irq_gate: assert property (@(posedge core_clk) disable iff (!rstn)
        (stat_q[3:0] & irq_enable) == 4'h0 |=> !irq_q) else $error("irq not gated");
    a_divide_by_four_rate: assert property (@(posedge core_clk) disable iff (!rstn)
        div_q == 8'h04 && tick_q && $stable(div_q) && !div_wr |=> !tick_q ##1 tick_q)
        else $error("divide by four rate wrong");

    c_tick: cover property (@(posedge core_clk) disable iff (!rstn) tick_q);
    c_irq: cover property (@(posedge core_clk) disable iff (!rstn) irq_q);
    c_set_clr: cover property (@(posedge core_clk) disable iff (!rstn) evt.tx_end && stat_rd);
    c_busy_end: cover property (@(posedge core_clk) disable iff (!rstn)
        $fell(stat_q[spips_pkg::BUSY_BIT]) && stat_q[spips_pkg::TEND_BIT]);
    c_divide_by_one_twenty_eight: cover property (@(posedge core_clk) disable iff (!rstn) div_q[7] && tick_q);
endmodule : spips_core

/* File: dv/spips_engine_model.sv */
// shift engine stand-in: drives the busy level and the event pulses on command
`timescale 1ns/1ps
module spips_engine_model (
    input  wire logic               core_clk, // oscillator clock
    input  wire logic               rstn,     // synchronous reset, active low
    input  wire logic               go,       // one-cycle command strobe
    input  wire logic [2:0]         kind,     // 0 start, 1 end, 2 ovr, 3 load, 4 fill
    output spips_pkg::spips_event_t evt       // events toward the block
);
    // pulses last one cycle; busy drops together with the end pulse, as a real shifter does
    always_ff @(posedge core_clk) begin
        evt.tx_end     <= rstn && go && kind == 3'h1;
        evt.rx_overrun <= rstn && go && kind == 3'h2;
        evt.tx_loaded  <= rstn && go && kind == 3'h3;
        evt.rx_filled  <= rstn && go && kind == 3'h4;
        evt.busy       <= rstn && (go ? kind == 3'h0 : evt.busy);
    end
endmodule : spips_engine_model

/* File: dv/tb.sv */
// self-checking bench for the spi prescaler and status block
`timescale 1ns/1ps
module tb;
    logic                    core_clk, rstn, tdb_wr, rdb_rd, go, sclk_tick, irq;
    logic [3:0]              irq_enable;
    logic [2:0]              kind;
    logic [7:0]              rdata, d;
    spips_pkg::spips_sfr_t   sfr;
    spips_pkg::spips_event_t evt;
    int                      n_fail, checked;
    spips_core spips_core_i (.core_clk(core_clk), .rstn(rstn), .sfr(sfr), .tdb_wr(tdb_wr),
        .rdb_rd(rdb_rd), .evt(evt), .irq_enable(irq_enable), .rdata(rdata),
        .sclk_tick(sclk_tick), .irq(irq));
    spips_engine_model spips_engine_model_i (.core_clk(core_clk), .rstn(rstn), .go(go),
        .kind(kind), .evt(evt));
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // one register cycle; read data lands in d one cycle after the strobe
    task automatic reg_acc(logic wr, logic [7:0] a, logic [7:0] wd);
        @(posedge core_clk);
        sfr <= '{wr: wr, rd: !wr, addr: a, wdata: wd};
        @(posedge core_clk);
        sfr <= '0;
        #1 d = rdata;
    endtask : reg_acc
    // one pulse from the engine or from software, then let flags settle;
    // the closing status read also clears the end and overrun flags
    task automatic pulse(logic e, logic [2:0] k, logic t, logic r);
        @(posedge core_clk);
        {go, kind, tdb_wr, rdb_rd} <= {e, k, t, r};
        @(posedge core_clk);
        {go, tdb_wr, rdb_rd} <= 3'b000;
        repeat (3) @(posedge core_clk);
        reg_acc(1'b0, 8'hD3, 8'h00);
    endtask : pulse
    task automatic t_regs;
        reg_acc(1'b0, 8'hD2, 8'h00);
        chk("divider reset", d, 8'h04);
        reg_acc(1'b0, 8'hD3, 8'h00);
        chk("status reset", d, 8'h02);
        reg_acc(1'b1, 8'hD3, 8'hFF);
        reg_acc(1'b0, 8'hD3, 8'h00);
        chk("status read only", d, 8'h02);
        reg_acc(1'b0, 8'h55, 8'h00);
        chk("unmapped read", d, 8'h00);
    endtask : t_regs
    // gap between ticks is half the divisor; stale ticks are skipped first
    task automatic t_divider;
        int n;
        for (int b = 2; b < 8; b++) begin
            reg_acc(1'b1, 8'hD2, (8'h01 << b) | 8'h03);
            reg_acc(1'b0, 8'hD2, 8'h00);
            chk("divider readback", d, 8'h01 << b);
            repeat (2) @(posedge core_clk iff sclk_tick);
            n = 0;
            do begin
                @(posedge core_clk);
                n++;
            end while (!sclk_tick);
            chk("tick gap", 8'(n), 8'(1 << (b - 1)));
        end
    endtask : t_divider
    task automatic t_flags;
        pulse(1'b1, 3'h0, 1'b0, 1'b0);
        chk("busy", d, 8'h12);
        pulse(1'b1, 3'h1, 1'b0, 1'b0);
        chk("end, busy gone", d, 8'h0A);
        pulse(1'b1, 3'h2, 1'b0, 1'b0);
        chk("overrun, end cleared", d, 8'h06);
        reg_acc(1'b0, 8'hD3, 8'h00);
        chk("cleared by read", d, 8'h02);
        pulse(1'b0, 3'h7, 1'b1, 1'b0);
        chk("tx buffer written", d, 8'h00);
        pulse(1'b1, 3'h3, 1'b0, 1'b0);
        chk("tx buffer loaded", d, 8'h02);
        pulse(1'b1, 3'h4, 1'b0, 1'b0);
        chk("rx buffer filled", d, 8'h03);
        pulse(1'b0, 3'h7, 1'b0, 1'b1);
        chk("rx buffer read", d, 8'h02);
    endtask : t_flags
    // end pulse and status read meet in one cycle: the hardware set must win
    task automatic t_collide;
        @(posedge core_clk);
        {go, kind} <= {1'b1, 3'h1};
        @(posedge core_clk);
        go  <= 1'b0;
        sfr <= '{wr: 1'b0, rd: 1'b1, addr: 8'hD3, wdata: 8'h00};
        @(posedge core_clk);
        sfr <= '0;
        reg_acc(1'b0, 8'hD3, 8'h00);
        chk("end beats read clear", d, 8'h0A);
        reg_acc(1'b0, 8'hD3, 8'h00);
        chk("end cleared later", d, 8'h02);
    endtask : t_collide
    // only tx-empty is set at first, so only its enable may raise the request
    task automatic t_irq;
        @(posedge core_clk);
        irq_enable <= 4'h2;
        repeat (3) @(posedge core_clk);
        chk("irq enabled", {7'h00, irq}, 8'h01);
        irq_enable <= 4'hD;
        repeat (3) @(posedge core_clk);
        chk("irq masked", {7'h00, irq}, 8'h00);
        irq_enable <= 4'h1;
        pulse(1'b1, 3'h4, 1'b0, 1'b0);
        chk("irq rx full", {7'h00, irq}, 8'h01);
        pulse(1'b0, 3'h7, 1'b0, 1'b1);
        chk("irq rx read", {7'h00, irq}, 8'h00);
    endtask : t_irq
    // reset in mid-run: the written divider and a set flag must fall back
    task automatic t_rerun;
        pulse(1'b1, 3'h4, 1'b0, 1'b0);
        @(posedge core_clk);
        rstn <= 1'b0;
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        reg_acc(1'b0, 8'hD2, 8'h00);
        chk("divider after reset", d, 8'h04);
        reg_acc(1'b0, 8'hD3, 8'h00);
        chk("status after reset", d, 8'h02);
        chk("irq after reset", {7'h00, irq}, 8'h00);
    endtask : t_rerun
    task automatic test_done;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : test_done
    initial begin
        {rstn, tdb_wr, rdb_rd, go, kind, irq_enable, sfr} = '0;
        repeat (12) @(posedge core_clk);
        rstn <= 1'b1;
        t_regs();
        t_divider();
        t_flags();
        t_collide();
        t_irq();
        t_rerun();
        test_done();
    end
    // watchdog: the whole run needs well under a thousand cycles
    initial begin
        #100000;
        n_fail++;
        test_done();
    end
endmodule : tb
